//--- src/fskmc_params.svh
// constants for the fsk modem control and timing block
`ifndef FSKMC_PARAMS_SVH
`define FSKMC_PARAMS_SVH

// system clock and the reference the delays were specified against
`define FSKMC_CLK_HZ          125000000
`define FSKMC_MASTER_HZ       3579545
// slow clock output frequency in tenths of a hertz (873.9 Hz)
`define FSKMC_CLKOUT_DHZ      8739
`define FSKMC_MS_CYC          (`FSKMC_CLK_HZ / 1000)
`define FSKMC_CLKOUT_HALF     ((`FSKMC_CLK_HZ * 10) / (2 * `FSKMC_CLKOUT_DHZ))

// two-select variant delays in ms, nominal or mid-range
`define FSKMC_HS_MS_00        8'd200
`define FSKMC_HS_MS_01        8'd30
`define FSKMC_HS_MS_10        8'd70
`define FSKMC_CDON_MS_2       8'd18
`define FSKMC_CDOFF_MS_2      8'd10
`define FSKMC_SQ_MS_0X        8'd150
`define FSKMC_SQ_MS_10        8'd40
// single-select variant delays in ms
`define FSKMC_HS_MS_1         8'd180
`define FSKMC_CDON_MS_1       8'd25
`define FSKMC_CDOFF_MS_1      8'd15
`define FSKMC_SQ_MS_1         8'd156

// wishbone byte addresses
`define FSKMC_ADR_CTRL        8'h00
`define FSKMC_ADR_STATUS      8'h04
// control register reset: squelch on, answer tone off, built-in 200 ms
`define FSKMC_CTRL_RST        8'h40

`endif

//--- src/fskmc_pkg.sv
// types for the fsk modem control and timing block
package fskmc_pkg;

    typedef enum logic [4:0] {
        LINE_IDLE   = 5'h01,
        LINE_MARK   = 5'h02,
        LINE_SPACE  = 5'h04,
        LINE_ANSWER = 5'h08,
        LINE_RXFILT = 5'h10
    } fskmc_line_t;

    typedef enum logic [2:0] {
        HS_IDLE  = 3'h1,
        HS_WAIT  = 3'h2,
        HS_CLEAR = 3'h4
    } fskmc_hs_t;

    typedef struct packed {
        logic filter_test_sel;
        logic answer_tone_en_n;
        logic squelch_ctl_n;
        logic loopback_sel;
        logic single_variant;
        logic delay_sel_single;
        logic delay_sel_hi;
        logic delay_sel_lo;
    } fskmc_ctrl_t;

    typedef struct packed {
        logic       ext;
        logic [7:0] hs_ms;
        logic [7:0] on_ms;
        logic [7:0] off_ms;
        logic [7:0] sq_ms;
    } fskmc_dly_t;

    typedef struct packed {
        fskmc_ctrl_t  ctrl;
        fskmc_hs_t    hs;
        logic [7:0]   hs_ms;
        logic [16:0]  ms_cnt;
        logic         ms_tick;
        logic [16:0]  div_cnt;
        logic         clk_out;
        logic [7:0]   cd_ms;
        logic         cd_on;
        logic [7:0]   sq_ms;
        logic         sq_hold;
        logic         req_n_prev;
        logic         cts_n;
        logic         cd_n_out;
        logic         cd_oe;
        logic         rx_data;
        logic         raw_out;
        fskmc_line_t  line;
        logic         ack;
        logic [31:0]  dat;
    } fskmc_state_t;

endpackage

//--- src/fskmc_top.sv
// control and timing logic of a 1200 bit/s half-duplex fsk modem
//
// Notes on behaviour
// - clear goes low only after handshake delay expires following request low, except in loopback
// - two-select codes 00/01/10 give 200/30/70 ms; 11 uses external delay
// - single-select low gives 180 ms, built-in carrier and 156 ms squelch delays
// - request high returns clear high within half a millisecond
// - raw carrier feeds delay; on after 10-25 ms, off after 5-15 ms
// - carrier pin is delayed output when built-in, input when external
// - one select code sets all delays together, none independently
// - loopback: tx data on receive output, request state straight onto clear
// - loopback: demodulated data modulates the transmitted carrier
// - loopback: loop carrier control, not request, gates line transmission
// - high bit sends mark, low space; outside loopback and filter test nothing sent unless request low
// - receive output forced mark without carrier, while squelched sending, in hold
// - squelch active when control low; hold 150/150/40 ms by code
// - raw demodulated bit has own output; separate input feeds output logic
// - single variant: answer tone enable and request low send answer tone, except in loopback or filter test
// - filter test routes receive filter to line output
// - slow 873.9 Hz clock output divided down from the system clock
// - master timing derived from the system clock, not the 3.579545 MHz reference
`timescale 1ns/1ps

`include "fskmc_params.svh"

module fskmc_top #(
    parameter logic [16:0] MS_CYC      = 17'(`FSKMC_MS_CYC),
    parameter logic [16:0] CLKOUT_HALF = 17'(`FSKMC_CLKOUT_HALF)
) (
    input  wire logic                clk_i,
    input  wire logic                rst_i,
    input  wire logic                wb_cyc_i,
    input  wire logic                wb_stb_i,
    input  wire logic                wb_we_i,
    input  wire logic [7:0]          wb_adr_i,
    input  wire logic [3:0]          wb_sel_i,
    input  wire logic [31:0]         wb_dat_i,
    output logic      [31:0]         wb_dat_o,
    output logic                     wb_ack_o,
    input  wire logic                tx_request_n_i,
    input  wire logic                ext_handshake_delay_n_i,
    input  wire logic                loop_carrier_ctl_n_i,
    input  wire logic                tx_bit_i,
    input  wire logic                fast_carrier_raw_i,
    input  wire logic                carrier_detect_n_i,
    output logic                     carrier_detect_n_o,
    output logic                     carrier_detect_n_oe_o,
    input  wire logic                demod_bit_i,
    output logic                     demod_raw_out_o,
    input  wire logic                demod_logic_in_i,
    output logic                     clear_n_o,
    output logic                     rx_data_o,
    output fskmc_pkg::fskmc_line_t   line_tx_sel_o,
    output logic                     slow_clk_o
);

    fskmc_pkg::fskmc_state_t st_q;
    fskmc_pkg::fskmc_state_t st_d;
    fskmc_pkg::fskmc_dly_t   dly;
    logic                    carrier_now;
    logic                    rx_force;
    logic                    tx_en;
    logic                    tx_bit;
    logic                    wb_req;

    // one code sets all
    // every delay of a code is fixed here, so no delay can be chosen alone
    function automatic fskmc_pkg::fskmc_dly_t dly_lookup(
        input fskmc_pkg::fskmc_ctrl_t c
    );
        fskmc_pkg::fskmc_dly_t r;
        r = '0;
        if (c.single_variant) begin
            r.ext    = c.delay_sel_single;
            r.hs_ms  = `FSKMC_HS_MS_1;
            r.on_ms  = `FSKMC_CDON_MS_1;
            r.off_ms = `FSKMC_CDOFF_MS_1;
            r.sq_ms  = `FSKMC_SQ_MS_1;
        end else begin
            r.on_ms  = `FSKMC_CDON_MS_2;
            r.off_ms = `FSKMC_CDOFF_MS_2;
            unique case ({c.delay_sel_hi, c.delay_sel_lo})
                2'b00: begin
                    r.hs_ms = `FSKMC_HS_MS_00;
                    r.sq_ms = `FSKMC_SQ_MS_0X;
                end
                2'b01: begin
                    r.hs_ms = `FSKMC_HS_MS_01;
                    r.sq_ms = `FSKMC_SQ_MS_0X;
                end
                2'b10: begin
                    r.hs_ms = `FSKMC_HS_MS_10;
                    r.sq_ms = `FSKMC_SQ_MS_10;
                end
                2'b11: begin
                    r.ext = 1'b1;
                end
            endcase
        end
        return r;
    endfunction

    assign dly    = dly_lookup(st_q.ctrl);
    assign wb_req = wb_cyc_i & wb_stb_i;

    always_comb begin
        st_d = st_q;

        // ms base from system clock
        // timers run off a millisecond prescaler rather than the 3.58 MHz
        // reference; the ms figures are kept the same
        st_d.ms_tick = 1'b0;
        if (st_q.ms_cnt >= MS_CYC - 17'h00001) begin
            st_d.ms_cnt  = '0;
            st_d.ms_tick = 1'b1;
        end else begin
            st_d.ms_cnt = st_q.ms_cnt + 17'h00001;
        end

        if (st_q.div_cnt >= CLKOUT_HALF - 17'h00001) begin
            st_d.div_cnt = '0;
            st_d.clk_out = ~st_q.clk_out;
        end else begin
            st_d.div_cnt = st_q.div_cnt + 17'h00001;
        end

        if (tx_request_n_i) begin
            st_d.hs    = fskmc_pkg::HS_IDLE;
            st_d.hs_ms = '0;
        end else begin
            unique case (st_q.hs)
                fskmc_pkg::HS_IDLE: begin
                    st_d.hs    = fskmc_pkg::HS_WAIT;
                    st_d.hs_ms = '0;
                end
                fskmc_pkg::HS_WAIT: begin
                    if (st_q.ms_tick) begin
                        st_d.hs_ms = st_q.hs_ms + 8'h01;
                    end
                    if (st_q.hs_ms >= dly.hs_ms) begin
                        st_d.hs = fskmc_pkg::HS_CLEAR;
                    end
                end
                fskmc_pkg::HS_CLEAR: begin
                    st_d.hs = fskmc_pkg::HS_CLEAR;
                end
            endcase
        end

        if (st_q.ctrl.loopback_sel) begin
            st_d.cts_n = tx_request_n_i;
        end else if (tx_request_n_i) begin
            st_d.cts_n = 1'b1;
        end else if (dly.ext) begin
            st_d.cts_n = ext_handshake_delay_n_i;
        end else begin
            st_d.cts_n = (st_q.hs != fskmc_pkg::HS_CLEAR);
        end

        // delayed carrier detect
        // a glitch on the raw detector resets the count, so the delay restarts
        if (fast_carrier_raw_i == st_q.cd_on) begin
            st_d.cd_ms = '0;
        end else begin
            if (st_q.ms_tick) begin
                st_d.cd_ms = st_q.cd_ms + 8'h01;
            end
            if (st_q.cd_ms >= (fast_carrier_raw_i ? dly.on_ms : dly.off_ms)) begin
                st_d.cd_on = fast_carrier_raw_i;
                st_d.cd_ms = '0;
            end
        end

        st_d.cd_oe    = ~dly.ext;
        st_d.cd_n_out = ~st_d.cd_on;
        carrier_now   = dly.ext ? ~carrier_detect_n_i : st_q.cd_on;

        st_d.req_n_prev = tx_request_n_i;
        if (st_q.ctrl.squelch_ctl_n || dly.ext || !tx_request_n_i) begin
            st_d.sq_hold = 1'b0;
            st_d.sq_ms   = '0;
        end else if (!st_q.req_n_prev) begin
            st_d.sq_hold = 1'b1;
            st_d.sq_ms   = '0;
        end else if (st_q.sq_hold) begin
            if (st_q.ms_tick) begin
                st_d.sq_ms = st_q.sq_ms + 8'h01;
            end
            if (st_q.sq_ms >= dly.sq_ms) begin
                st_d.sq_hold = 1'b0;
            end
        end

        rx_force = ~carrier_now
                 | (~st_q.ctrl.squelch_ctl_n & ~tx_request_n_i)
                 | st_d.sq_hold;

        // raw bit out, logic input used
        st_d.raw_out = demod_bit_i;
        if (st_q.ctrl.loopback_sel) begin
            st_d.rx_data = tx_bit_i;
        end else begin
            st_d.rx_data = rx_force | demod_logic_in_i;
        end

        tx_en  = st_q.ctrl.loopback_sel ? ~loop_carrier_ctl_n_i : ~tx_request_n_i;
        tx_bit = st_q.ctrl.loopback_sel ? demod_logic_in_i : tx_bit_i;
        if (st_q.ctrl.filter_test_sel) begin
            st_d.line = fskmc_pkg::LINE_RXFILT;
        end else if (st_q.ctrl.single_variant && !st_q.ctrl.answer_tone_en_n
                     && !st_q.ctrl.loopback_sel && !tx_request_n_i) begin
            st_d.line = fskmc_pkg::LINE_ANSWER;
        end else if (tx_en) begin
            st_d.line = tx_bit ? fskmc_pkg::LINE_MARK : fskmc_pkg::LINE_SPACE;
        end else begin
            st_d.line = fskmc_pkg::LINE_IDLE;
        end

        // wishbone: one wait state, ack dropped the cycle after it is given
        st_d.ack = wb_req & ~st_q.ack;
        st_d.dat = '0;
        if (wb_req && !st_q.ack) begin
            unique case (wb_adr_i)
                `FSKMC_ADR_CTRL: begin
                    st_d.dat = {24'h000000, st_q.ctrl};
                    if (wb_we_i && wb_sel_i[0]) begin
                        st_d.ctrl = fskmc_pkg::fskmc_ctrl_t'(wb_dat_i[7:0]);
                    end
                end
                `FSKMC_ADR_STATUS: begin
                    st_d.dat = {22'h000000, st_q.line, dly.ext, rx_force,
                                st_q.sq_hold, carrier_now, ~st_q.cts_n};
                end
                default: begin
                    st_d.dat = '0;
                end
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st_q          <= '0;
            st_q.ctrl     <= fskmc_pkg::fskmc_ctrl_t'(`FSKMC_CTRL_RST);
            st_q.hs       <= fskmc_pkg::HS_IDLE;
            st_q.req_n_prev <= 1'b1;
            st_q.cts_n    <= 1'b1;
            st_q.cd_n_out <= 1'b1;
            st_q.cd_oe    <= 1'b1;
            st_q.rx_data  <= 1'b1;
            st_q.line     <= fskmc_pkg::LINE_IDLE;
        end else begin
            st_q <= st_d;
        end
    end

    assign wb_dat_o              = st_q.dat;
    assign wb_ack_o              = st_q.ack;
    assign clear_n_o             = st_q.cts_n;
    assign carrier_detect_n_o    = st_q.cd_n_out;
    assign carrier_detect_n_oe_o = st_q.cd_oe;
    assign rx_data_o             = st_q.rx_data;
    assign demod_raw_out_o       = st_q.raw_out;
    assign line_tx_sel_o         = st_q.line;
    assign slow_clk_o            = st_q.clk_out;

    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    cts_release_a: assert property (
        $rose(tx_request_n_i) |=> clear_n_o)
        else $error("clear did not release after request went high");

    cts_hold_a: assert property (
        ($fell(tx_request_n_i) && !st_q.ctrl.loopback_sel && !dly.ext)
            |=> clear_n_o [*8])
        else $error("clear went low before the handshake delay");

    loop_clear_a: assert property (
        st_q.ctrl.loopback_sel |=> clear_n_o == $past(tx_request_n_i))
        else $error("loopback clear does not follow request");

    loop_data_a: assert property (
        st_q.ctrl.loopback_sel |=> rx_data_o == $past(tx_bit_i))
        else $error("loopback receive data does not follow transmit data");

    rx_mark_a: assert property (
        (!st_q.ctrl.loopback_sel && !carrier_now) |=> rx_data_o)
        else $error("receive data not forced to mark without carrier");

    squelch_hold_a: assert property (
        ($rose(tx_request_n_i) && !st_q.ctrl.squelch_ctl_n && !dly.ext
            && !st_q.ctrl.loopback_sel && !wb_req)
            |=> rx_data_o [*4])
        else $error("receive data not held at mark after transmit ended");

    line_quiet_a: assert property (
        (tx_request_n_i && !st_q.ctrl.loopback_sel && !st_q.ctrl.filter_test_sel)
            |=> line_tx_sel_o == fskmc_pkg::LINE_IDLE)
        else $error("line output active without transmit request");

    loop_gate_a: assert property (
        (st_q.ctrl.loopback_sel && loop_carrier_ctl_n_i && !st_q.ctrl.filter_test_sel)
            |=> line_tx_sel_o == fskmc_pkg::LINE_IDLE)
        else $error("loopback line active without loop carrier control");

    ftest_route_a: assert property (
        st_q.ctrl.filter_test_sel |=> line_tx_sel_o == fskmc_pkg::LINE_RXFILT)
        else $error("filter test does not route receive filter");

    cd_dir_a: assert property (
        dly.ext |=> !carrier_detect_n_oe_o)
        else $error("carrier pin driven in external delay mode");

endmodule

//--- verification/fskmc_dte_model.sv
// terminal-side model: request line, data bit and an external handshake delay circuit
`timescale 1ns/1ps
module fskmc_dte_model #(
    parameter int EXT_CYC = 37
) (
    input  wire logic clk_i,
    input  wire logic send_i,
    input  wire logic bit_i,
    output logic      tx_request_n_o = 1'b1,
    output logic      tx_bit_o = 1'b0,
    output logic      ext_handshake_delay_n_o = 1'b1
);
    int cnt = 0;
    // request held low for whole send
    always @(posedge clk_i) begin
        tx_request_n_o <= ~send_i;
        tx_bit_o       <= bit_i;
    end
    always @(posedge clk_i) begin
        if (tx_request_n_o) begin
            cnt <= 0;
        end else if (cnt < EXT_CYC) begin
            cnt <= cnt + 1;
        end
        ext_handshake_delay_n_o <= !(cnt >= EXT_CYC - 1 && !tx_request_n_o);
    end
endmodule

//--- verification/fskmc_top_bench.sv
// self-checking bench for the fsk modem control and timing block
`timescale 1ns/1ps
module fskmc_top_bench;
    localparam logic [16:0] MS   = 17'h0000a;
    localparam logic [16:0] HALF = 17'h00004;
    localparam int          EXT  = 37;
    localparam int          M    = 10;
    logic        clk_i = 1'b0;
    logic        rst_i = 1'b1;
    logic        cyc = 1'b0, stb = 1'b0, we = 1'b0, ack;
    logic [7:0]  adr = 8'h00;
    logic [31:0] wdat = 32'h0, rdat, rd;
    logic        send = 1'b0, dbit = 1'b0, req_n, txb, ext_n, loop_cc_n = 1'b1;
    logic        raw_cd = 1'b0, cd_drv_n = 1'b1, demod = 1'b0, logic_in = 1'b1;
    logic        cd_o_n, cd_oe, raw_out, clear_n, rx_data, slow_clk;
    fskmc_pkg::fskmc_line_t line;
    // pin level: block drives when enabled, else the outside circuit
    wire         cd_pin_n = cd_oe ? cd_o_n : cd_drv_n;
    int          n_mismatch = 0;
    int          tests_run = 0;
    int          n, n1, lo, hi;
    logic [7:0]  codes [4] = '{8'h40, 8'h41, 8'h42, 8'h48};

    always #4 clk_i = ~clk_i;

    fskmc_dte_model #(.EXT_CYC(EXT)) dte (.clk_i(clk_i), .send_i(send), .bit_i(dbit),
        .tx_request_n_o(req_n), .tx_bit_o(txb), .ext_handshake_delay_n_o(ext_n));

    fskmc_top #(.MS_CYC(MS), .CLKOUT_HALF(HALF)) uut (.clk_i(clk_i), .rst_i(rst_i),
        .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf),
        .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .tx_request_n_i(req_n),
        .ext_handshake_delay_n_i(ext_n), .loop_carrier_ctl_n_i(loop_cc_n), .tx_bit_i(txb),
        .fast_carrier_raw_i(raw_cd), .carrier_detect_n_i(cd_pin_n),
        .carrier_detect_n_o(cd_o_n), .carrier_detect_n_oe_o(cd_oe), .demod_bit_i(demod),
        .demod_raw_out_o(raw_out), .demod_logic_in_i(logic_in), .clear_n_o(clear_n),
        .rx_data_o(rx_data), .line_tx_sel_o(line), .slow_clk_o(slow_clk));

    task chk_val(input string nm, input logic [31:0] exp, input logic [31:0] got);
        tests_run++;
        if (got !== exp) begin
            n_mismatch++;
            $display("wrong value %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task chk_time(input string nm, input int lo_c, input int hi_c, input int got);
        tests_run++;
        if (got < lo_c || got > hi_c) begin
            n_mismatch++;
            $display("wrong value %s expected %0d..%0d seen %0d", nm, lo_c, hi_c, got);
        end
    endtask
    task final_report;
        $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    // single classic cycle; waits for ack under a bound
    task wb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
        int k;
        @(posedge clk_i);
        cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; wdat <= d;
        k = 0;
        do begin
            @(posedge clk_i);
            k++;
        end while (ack !== 1'b1 && k < 50);
        q = rdat;
        cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
        if (k >= 50) chk_val("bus ack", 1, 0);
    endtask
    function automatic logic pick(input int k);
        case (k)
            0: return clear_n;
            1: return cd_o_n;
            2: return rx_data;
            3: return slow_clk;
            default: return req_n;
        endcase
    endfunction
    task automatic wait_for(input int k, input logic lvl, input int lim, output int c);
        c = 0;
        while (pick(k) !== lvl && c < lim) begin
            @(posedge clk_i);
            #1;
            c++;
        end
    endtask
    task req(input logic on);
        int c;
        @(posedge clk_i);
        send <= on;
        wait_for(4, !on, 20, c);
    endtask
    function automatic int hs_ms(input logic [7:0] c);
        if (c[3]) return 180;
        case (c[1:0])
            2'b00: return 200;
            2'b01: return 30;
            default: return 70;
        endcase
    endfunction
    function automatic int sq_ms(input logic [7:0] c);
        if (c[3]) return 156;
        return (c[1:0] == 2'b10) ? 40 : 150;
    endfunction

    initial begin
        repeat (60000) @(posedge clk_i);
        n_mismatch++;
        $display("wrong value watchdog expected finish seen hang");
        final_report();
    end

    initial begin
        void'($urandom(32'h6f2f));
        repeat (16) @(posedge clk_i);
        rst_i <= 1'b0;
        #1;
        chk_val("clear at reset", 1, clear_n);
        chk_val("line at reset", fskmc_pkg::LINE_IDLE, line);
        wb(1'b0, 8'h00, 0, rd); chk_val("ctrl reset", 32'h40, rd);
        wb(1'b0, 8'h08, 0, rd); chk_val("unmapped", 0, rd);
        wb(1'b1, 8'hfc, 32'hff, rd); wb(1'b1, 8'h00, 32'hffff_ff5a, rd);
        wb(1'b0, 8'h00, 0, rd); chk_val("ctrl rw", 32'h5a, rd);
        // align on a fresh falling edge, then time one full low half period
        wait_for(3, 1, 20, n); wait_for(3, 0, 20, n); wait_for(3, 1, 20, n);
        chk_time("slow clock half", int'(HALF) - 1, int'(HALF) + 1, n);
        logic_in <= 1'b0;
        foreach (codes[i]) begin
            wb(1'b1, 8'h00, {24'h0, codes[i]}, rd);
            chk_val("carrier pin enable", 1, cd_oe);
            lo = codes[i][3] ? 15 : 10;
            hi = codes[i][3] ? 35 : 25;
            @(posedge clk_i); raw_cd <= 1'b1; #1;
            wait_for(1, 0, (hi + 2) * M, n);
            chk_time("carrier on", lo * M - 2, hi * M + 3, n);
            req(1'b1);
            wait_for(0, 0, (hs_ms(codes[i]) + 3) * M, n);
            // first ms tick may land at once, so the count spans one tick phase
            chk_time("handshake", (hs_ms(codes[i]) - 1) * M + 4, hs_ms(codes[i]) * M + 3, n);
            chk_val("rx squelched send", 1, rx_data);
            repeat (4) begin
                @(posedge clk_i); dbit <= 1'($urandom); demod <= 1'($urandom);
                repeat (3) @(posedge clk_i); #1;
                chk_val("line bit", dbit ? fskmc_pkg::LINE_MARK : fskmc_pkg::LINE_SPACE, line);
                chk_val("raw demod", demod, raw_out);
            end
            req(1'b0);
            wait_for(0, 1, 10, n1);
            chk_time("clear release", 0, M / 2, n1);
            wait_for(2, 0, (sq_ms(codes[i]) + 3) * M, n);
            chk_time("squelch hold", (sq_ms(codes[i]) - 1) * M + 3, sq_ms(codes[i]) * M + 2, n + n1);
            chk_val("line idle", fskmc_pkg::LINE_IDLE, line);
            @(posedge clk_i); raw_cd <= 1'b0; #1;
            lo = codes[i][3] ? 10 : 5;
            hi = codes[i][3] ? 20 : 15;
            wait_for(1, 1, (hi + 2) * M, n);
            chk_time("carrier off", lo * M - 2, hi * M + 3, n);
            #16; chk_val("rx no carrier", 1, rx_data);
        end
        wb(1'b1, 8'h00, 32'h43, rd);
        @(posedge clk_i); cd_drv_n <= 1'b0; #16;
        chk_val("carrier pin released", 0, cd_oe);
        wb(1'b0, 8'h04, 0, rd); chk_val("ext carrier status", 1, rd[1]);
        req(1'b1);
        wait_for(0, 0, EXT + 10, n); chk_time("ext handshake", EXT - 2, EXT + 4, n);
        req(1'b0);
        wait_for(0, 1, 10, n); chk_time("ext release", 0, M / 2, n);
        wb(1'b1, 8'h00, 32'h08, rd); req(1'b1); #32;
        chk_val("answer tone", fskmc_pkg::LINE_ANSWER, line);
        req(1'b0); wb(1'b1, 8'h00, 32'hc0, rd); #32;
        chk_val("filter test", fskmc_pkg::LINE_RXFILT, line);
        wb(1'b1, 8'h00, 32'h50, rd);
        @(posedge clk_i); loop_cc_n <= 1'b0;
        repeat (4) begin
            @(posedge clk_i); dbit <= 1'($urandom); logic_in <= 1'($urandom); demod <= logic_in;
            repeat (4) @(posedge clk_i); #1;
            chk_val("loop rx", dbit, rx_data);
            chk_val("loop carrier", logic_in ? fskmc_pkg::LINE_MARK : fskmc_pkg::LINE_SPACE, line);
        end
        @(posedge clk_i); loop_cc_n <= 1'b1;
        req(1'b1);
        wait_for(0, 0, 10, n); chk_time("loop clear", 0, 2, n);
        #16; chk_val("loop no carrier", fskmc_pkg::LINE_IDLE, line);
        req(1'b0);
        final_report();
    end
endmodule
